// *** logic/gar_pkg.sv ***
// Package of constants shared by the gauge alert register block and its I2C master.
package gar_pkg;

	// ************************************************************
	// Clock and link timing.
	// ************************************************************
	localparam int CLK_HZ = 200000000;         // System clock rate.
	localparam int SCL_HALF_CYC = 250;         // Half SCL period of the master, 400 kHz.
	localparam int PULSE_MS = 1;               // Alert pulse length in milliseconds.
	localparam int REPEAT_S = 1;               // Least gap between repeated alert pulses.
	localparam int STALE_S = 16;               // Host temperature freshness window.
	localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
	localparam int REPEAT_CYC = CLK_HZ * REPEAT_S;
	localparam longint STALE_CYC = longint'(CLK_HZ) * STALE_S;

	// ************************************************************
	// Bus address and register indices.
	// ************************************************************
	localparam logic [6:0] DEV_ADDR = 7'h63;   // Fixed seven-bit slave address.
	localparam logic [7:0] REG_ALERT_CONFIG = 8'h0a;
	localparam logic [7:0] REG_CHARGE_ALERT_LEVEL = 8'h0b;
	localparam logic [7:0] REG_TEMP_UPPER_LIMIT = 8'h0c;
	localparam logic [7:0] REG_TEMP_LOWER_LIMIT = 8'h0d;
	localparam logic [7:0] REG_ID_VOLT_H = 8'h0e;
	localparam logic [7:0] REG_ID_VOLT_L = 8'h0f;
	localparam logic [7:0] REG_HOST_TEMP_H = 8'ha0;
	localparam logic [7:0] REG_HOST_TEMP_L = 8'ha1;

	// ************************************************************
	// Reset values and fields.
	// ************************************************************
	localparam logic [7:0] RST_ALERT_CONFIG = 8'h40;
	localparam logic [7:0] RST_CHARGE_ALERT_LEVEL = 8'h14;
	localparam logic [7:0] RST_TEMP_UPPER_LIMIT = 8'haa;
	localparam logic [7:0] RST_TEMP_LOWER_LIMIT = 8'h50;
	localparam logic [6:0] LEVEL_ANY_MIN = 7'h65; // Levels from here up alert on any change.
	localparam int BIT_LOADED = 7;             // Profile-loaded marker bit.
	localparam int BIT_CHARGE = 0;             // Flag and enable offsets within the nibble.
	localparam int BIT_OVER = 1;
	localparam int BIT_UNDER = 2;
	localparam int EN_SHIFT = 4;               // Enables sit above the flags.

	// ************************************************************
	// Master command port encodings.
	// ************************************************************
	localparam logic [7:0] CMD_START = 8'h00;
	localparam logic [7:0] CMD_STATUS = 8'h04;
	localparam logic [7:0] CMD_RDATA = 8'h08;

endpackage

// *** logic/gar_if.sv ***
// Interface carrying the two-wire link between host master and gauge slave.
`timescale 1ns/1ps
interface gar_if;
	logic scl_o;    // Master SCL drive value.
	logic scl_oe;   // Master drives SCL low while high.
	logic msda_o;   // Master SDA value.
	logic msda_oe;  // Master drives SDA.
	logic ssda_o;   // Slave SDA value.
	logic ssda_oe;  // Slave drives SDA.
	wire scl = ~(scl_oe & ~scl_o);
	wire sda = ~((msda_oe & ~msda_o) | (ssda_oe & ~ssda_o));

	modport master (output scl_o, scl_oe, msda_o, msda_oe, input scl, sda);
	modport slave (output ssda_o, ssda_oe, input scl, sda);
endinterface

// *** logic/gar_pulse.sv ***
// Alert pulse generator: one low pulse per event outside a running pulse or its guard gap, repeated while the cause stays.
`timescale 1ns/1ps
module gar_pulse
	import gar_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_event,
	input wire logic i_persist,
	output logic o_alert_b
);
	logic [31:0] cnt_q;   // Cycles since the current pulse began.
	logic busy_q;         // A pulse or its guard gap is running.

	// ************************************************************
	// Pulse and repeat timer.
	// ************************************************************
	// Low pulse of about 1 ms; any repeat starts at least 1 s after the previous pulse began.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
			o_alert_b <= 1'b1;
		end
		else if (!busy_q)
		begin
			if (i_event | i_persist)
			begin
				busy_q <= 1'b1; // R22
				cnt_q <= 32'h0;
				o_alert_b <= 1'b0;
			end
		end
		else
		begin
			cnt_q <= cnt_q + 32'h1;
			if (cnt_q == 32'(PULSE_CYC - 1))
				o_alert_b <= 1'b1;
			if (cnt_q == 32'(REPEAT_CYC - 1))
				busy_q <= 1'b0; // R22
		end
	end
endmodule

// *** logic/gar_slave.sv ***
// Gauge alert register bank with its I2C slave port.
// Overview of operation
// R1 - Profile-loaded marker bit resets to zero.
// R2 - Charge flag when charge reaches alert level.
// R3 - Levels 0x65 and above alert every change.
// R4 - Upper temperature limit sets over-temperature flag.
// R5 - Lower temperature limit sets under-temperature flag.
// R6 - Signed 14-bit ID voltage in two bytes.
// R7 - Host temperature is writable 16-bit register.
// R8 - Host refreshes temperature every 16 s.
// R9 - Stale host temperature sets over-temperature flag.
// R10 - Stale alarm suppressed while enable is zero.
// R11 - Writing zero clears the over-temperature flag.
// R12 - Slave only, standard and fast rates.
// R13 - Link idle until power-on reset releases.
// R14 - SDA changes only while SCL is low.
// R15 - START and STOP framed by master.
// R16 - Eight bits, MSB first, then acknowledge.
// R17 - Master waits while slave holds SCL.
// R18 - Receiver acknowledges low on ninth clock.
// R19 - Address, direction bit, STOP ends transfer.
// R20 - Respond only to address 0b1100011.
// R21 - Master makes every SCL pulse.
// R22 - Alert pin low about 1 ms, repeating.
// R23 - Enables in upper nibble, flags in lower.
// R24 - Index byte first, then auto-increment.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module gar_slave
	import gar_pkg::*;
#(
	parameter longint STALE_CYCLES = STALE_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	gar_if.slave bus,
	input wire logic [7:0] i_charge_pct,
	input wire logic [7:0] i_temp,
	input wire logic [13:0] i_id_volt,
	input wire logic i_host_temp_mode,
	output logic o_alert_b,
	output logic [15:0] o_host_temp
);
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WIDX, ST_DATA} gar_state_e;

	logic [1:0] scl_s_q;      // SCL synchroniser.
	logic [1:0] sda_s_q;      // SDA synchroniser.
	logic scl_q;              // Last synchronised SCL.
	logic sda_q;              // Last synchronised SDA.
	gar_state_e state_q;      // Byte phase of the transfer.
	logic [3:0] bit_q;        // Bit position, 8 is the acknowledge slot.
	logic [7:0] sh_q;         // Shift register.
	logic rd_q;               // Current transfer is a read.
	logic ack_q;              // Slave drives acknowledge in slot.
	logic mack_q;             // SDA was low at the last acknowledge rise, including our own address acknowledge.
	logic [7:0] idx_q;        // Register index.
	logic [7:0] conf_q;       // Alert configuration.
	logic [7:0] level_q;      // Marker bit and charge alert level.
	logic [7:0] tmax_q;
	logic [7:0] tmin_q;
	logic [63:0] stale_q;     // Cycles since last fresh host temperature.
	logic [7:0] last_lo_q;    // Previous host low byte.
	logic [7:0] pct_q;        // Previous charge percentage.
	logic wr_stb;             // Received data byte ready to store.
	logic [7:0] rdata;        // Register read mux.
	logic ev_chg, ev_over, ev_under, stale;

	wire scl_rise = scl_s_q[1] & ~scl_q;
	wire scl_fall = ~scl_s_q[1] & scl_q;
	wire start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1]; // R15
	wire stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];  // R15

	// ************************************************************
	// Pin sampling.
	// ************************************************************
	// Two flops on each pin; the link is held idle while reset is low.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_s_q <= 2'h3; // R13
			sda_s_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[0], bus.scl};
			sda_s_q <= {sda_s_q[0], bus.sda};
			scl_q <= scl_s_q[1];
			sda_q <= sda_s_q[1];
		end
	end

	// ************************************************************
	// Register read mux.
	// ************************************************************
	always_comb
	begin
		unique case (idx_q)
			REG_ALERT_CONFIG: rdata = conf_q;
			REG_CHARGE_ALERT_LEVEL: rdata = level_q;
			REG_TEMP_UPPER_LIMIT: rdata = tmax_q;
			REG_TEMP_LOWER_LIMIT: rdata = tmin_q;
			REG_ID_VOLT_H: rdata = {{2{i_id_volt[13]}}, i_id_volt[13:8]}; // R6
			REG_ID_VOLT_L: rdata = i_id_volt[7:0]; // R6
			REG_HOST_TEMP_H: rdata = o_host_temp[15:8];
			REG_HOST_TEMP_L: rdata = o_host_temp[7:0];
			default: rdata = 8'h00;
		endcase
	end

	// ************************************************************
	// Byte engine.
	// ************************************************************
	// Bits are taken on SCL rise, driven after SCL fall, ninth slot is acknowledge.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			mack_q <= 1'b0;
			idx_q <= 8'h00;
			wr_stb <= 1'b0;
			bus.ssda_o <= 1'b1;
			bus.ssda_oe <= 1'b0;
		end
		else
		begin
			wr_stb <= 1'b0;
			// The store uses the old index this cycle; step it for the next byte.
			if (wr_stb)
				idx_q <= idx_q + 8'h1; // R24
			if (start_c)
			begin
				state_q <= ST_ADDR; // R19
				bit_q <= 4'h0;
				bus.ssda_oe <= 1'b0;
			end
			else if (stop_c)
			begin
				state_q <= ST_IDLE; // R15
				bus.ssda_oe <= 1'b0;
			end
			else if (state_q != ST_IDLE && scl_rise)
			begin
				if (bit_q < 4'h8)
				begin
					sh_q <= {sh_q[6:0], sda_s_q[1]}; // R16
					bit_q <= bit_q + 4'h1;
				end
				else
				begin
					mack_q <= ~sda_s_q[1]; // R18
					bit_q <= 4'h9;
				end
			end
			else if (state_q != ST_IDLE && scl_fall)
			begin
				bus.ssda_oe <= 1'b0; // R14
				if (bit_q == 4'h8)
				begin
					ack_q <= 1'b0;
					unique case (state_q)
						ST_ADDR:
						begin
							if (sh_q[7:1] == DEV_ADDR) // R20
							begin
								ack_q <= 1'b1;
								rd_q <= sh_q[0];
								state_q <= sh_q[0] ? ST_DATA : ST_WIDX;
							end
							else
								state_q <= ST_IDLE;
						end
						ST_WIDX:
						begin
							idx_q <= sh_q; // R24
							ack_q <= 1'b1;
							state_q <= ST_DATA;
						end
						default:
						begin
							if (!rd_q)
							begin
								wr_stb <= 1'b1;
								ack_q <= 1'b1;
							end
						end
					endcase
					if (!(state_q == ST_DATA && rd_q) || state_q == ST_ADDR)
					begin
						bus.ssda_oe <= (state_q != ST_ADDR) | (sh_q[7:1] == DEV_ADDR);
						bus.ssda_o <= 1'b0; // R18
					end
				end
				else if (bit_q == 4'h9)
				begin
					bit_q <= 4'h0;
					if (state_q == ST_DATA && rd_q && mack_q)
						idx_q <= idx_q + 8'h1; // R24
					if (state_q == ST_DATA && rd_q && (ack_q || mack_q))
					begin
						// The rise shift reloads each sent bit, so sh_q[7] is the next one.
						sh_q <= rdata;
						bus.ssda_oe <= ~rdata[7]; // R16
						bus.ssda_o <= 1'b0;
					end
					else if (state_q == ST_DATA && rd_q)
						state_q <= ST_IDLE; // R18
					ack_q <= 1'b0;
					mack_q <= 1'b0;
				end
				else if (state_q == ST_DATA && rd_q && bit_q != 4'h0)
				begin
					bus.ssda_oe <= ~sh_q[7]; // R14
					bus.ssda_o <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Alert sources.
	// ************************************************************
	// Charge level crossing, limit reach, and stale host temperature.
	always_comb
	begin
		ev_chg = (i_charge_pct != pct_q) &&
			((level_q[6:0] >= LEVEL_ANY_MIN) || (i_charge_pct[6:0] == level_q[6:0])); // R2 R3
		ev_over = (i_temp >= tmax_q); // R4
		ev_under = (i_temp <= tmin_q); // R5
		stale = i_host_temp_mode && (stale_q >= 64'(STALE_CYCLES)) &&
			conf_q[EN_SHIFT + BIT_OVER]; // R9 R10
	end

	// Host temperature freshness: a write of the low byte that changes its value.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			stale_q <= 64'h0;
			last_lo_q <= 8'h00;
		end
		else if (wr_stb && idx_q == REG_HOST_TEMP_L && sh_q != last_lo_q)
		begin
			stale_q <= 64'h0; // R8
			last_lo_q <= sh_q;
		end
		else if (stale_q < 64'(STALE_CYCLES))
			stale_q <= stale_q + 64'h1;
	end

	// ************************************************************
	// Writable registers.
	// ************************************************************
	// Hardware sets of flags win over a software write in the same cycle.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			conf_q <= RST_ALERT_CONFIG;
			level_q <= RST_CHARGE_ALERT_LEVEL; // R1
			tmax_q <= RST_TEMP_UPPER_LIMIT;
			tmin_q <= RST_TEMP_LOWER_LIMIT;
			o_host_temp <= 16'h0000;
			pct_q <= 8'h00;
		end
		else
		begin
			pct_q <= i_charge_pct;
			if (wr_stb)
			begin
				unique case (idx_q)
					REG_ALERT_CONFIG: conf_q <= sh_q; // R11 R23
					REG_CHARGE_ALERT_LEVEL: level_q <= sh_q; // R1
					REG_TEMP_UPPER_LIMIT: tmax_q <= sh_q;
					REG_TEMP_LOWER_LIMIT: tmin_q <= sh_q;
					REG_HOST_TEMP_H: o_host_temp[15:8] <= sh_q; // R7
					REG_HOST_TEMP_L: o_host_temp[7:0] <= sh_q; // R7
					default: ;
				endcase
			end
			if (ev_chg && conf_q[EN_SHIFT + BIT_CHARGE])
				conf_q[BIT_CHARGE] <= 1'b1; // R2
			if ((ev_over && conf_q[EN_SHIFT + BIT_OVER]) || stale)
				conf_q[BIT_OVER] <= 1'b1; // R4 R9
			if (ev_under && conf_q[EN_SHIFT + BIT_UNDER])
				conf_q[BIT_UNDER] <= 1'b1; // R5
		end
	end

	// ************************************************************
	// Alert pin.
	// ************************************************************
	gar_pulse u_pulse (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_event(ev_chg & conf_q[EN_SHIFT + BIT_CHARGE]),
		.i_persist((ev_over & conf_q[EN_SHIFT + BIT_OVER]) | stale |
			(ev_under & conf_q[EN_SHIFT + BIT_UNDER])),
		.o_alert_b(o_alert_b)
	);
endmodule

// *** logic/gar_master.sv ***
// Host-side I2C master for the gauge register bank, driven by a small command port.
`timescale 1ns/1ps
module gar_master
	import gar_pkg::*;
#(
	parameter int HALF_CYC = SCL_HALF_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	gar_if.master bus,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata
);
	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_RSTART, M_STOP} gar_mstate_e;

	gar_mstate_e st_q;
	logic [7:0] div_q;        // Half-period counter.
	logic ph_q;               // Low or high half of SCL.
	logic [3:0] bit_q;        // Bit within byte, 8 is acknowledge.
	logic [1:0] byte_q;       // Byte number in the transfer.
	logic [7:0] sh_q;
	logic rd_op_q;            // Read of one register.
	logic [7:0] idx_q;        // Register index to access.
	logic [7:0] wbyte_q;      // Data byte to write.
	logic [7:0] rbyte_q;      // Received byte.
	logic nack_q;             // Slave refused a byte.
	logic busy_q;
	logic [1:0] sda_s_q;      // SDA synchroniser.
	wire tick = (div_q == 8'(HALF_CYC - 1));

	// ************************************************************
	// Command port reads.
	// ************************************************************
	// Read data stands one cycle after the strobe.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= (i_addr == CMD_STATUS) ? {6'h00, nack_q, busy_q} :
				(i_addr == CMD_RDATA) ? rbyte_q : 8'h00;
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sda_s_q <= 2'h3;
		else
			sda_s_q <= {sda_s_q[0], bus.sda};
	end

	// ************************************************************
	// Transfer sequencer.
	// ************************************************************
	// A write of CMD_START begins: i_wdata[15:8] index, [7:0] data; all-ones data reads.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_q <= M_IDLE;
			div_q <= 8'h00;
			ph_q <= 1'b0;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			sh_q <= 8'h00;
			rd_op_q <= 1'b0;
			idx_q <= 8'h00;
			wbyte_q <= 8'h00;
			rbyte_q <= 8'h00;
			nack_q <= 1'b0;
			busy_q <= 1'b0;
			bus.scl_o <= 1'b1;
			bus.scl_oe <= 1'b0;
			bus.msda_o <= 1'b1;
			bus.msda_oe <= 1'b0;
		end
		else
		begin
			div_q <= tick ? 8'h00 : div_q + 8'h1;
			unique case (st_q)
				M_IDLE:
					if (i_wr && i_addr == CMD_START)
					begin
						idx_q <= i_wdata[15:8];
						wbyte_q <= i_wdata[7:0];
						rd_op_q <= (i_wdata[7:0] == 8'hff);
						ph_q <= 1'b0;
						busy_q <= 1'b1;
						nack_q <= 1'b0;
						byte_q <= 2'h0;
						st_q <= M_START;
						div_q <= 8'h00;
					end
				M_START:
					if (tick)
					begin
						if (!ph_q)
						begin
							// SDA falls a full half period before SCL does.
							bus.msda_oe <= 1'b1; // R15
							bus.msda_o <= 1'b0;
							sh_q <= {DEV_ADDR, byte_q == 2'h2}; // R19
							bit_q <= 4'h0;
							ph_q <= 1'b1;
						end
						else
						begin
							bus.scl_oe <= 1'b1; // R21
							bus.scl_o <= 1'b0;
							ph_q <= 1'b0;
							st_q <= M_BIT;
						end
					end
				M_BIT:
					if (tick)
					begin
						// Phase flag high means SCL released; a held-low SCL stretches it.
						if (!ph_q)
						begin
							bus.scl_oe <= 1'b0; // R21
							ph_q <= 1'b1;
						end
						else if (bus.scl) // R17
						begin
							bus.scl_oe <= 1'b1; // R21
							bus.scl_o <= 1'b0;
							ph_q <= 1'b0;
						end
					end
					else if (div_q == 8'(HALF_CYC / 2) && !ph_q)
					begin
						// Mid low phase: present the next bit, or release SDA for the acknowledge slot.
						if (bit_q < 4'h8)
						begin
							bus.msda_oe <= ~(sh_q[7] | (byte_q == 2'h3)); // R14
							bus.msda_o <= 1'b0;
						end
						else
							bus.msda_oe <= (byte_q == 2'h3) ? 1'b0 : 1'b0;
					end
					else if (div_q == 8'(HALF_CYC / 2) && ph_q && bus.scl)
					begin
						// Mid high phase: sample SDA and step the bit count.
						if (bit_q < 4'h8)
						begin
							sh_q <= {sh_q[6:0], 1'b0};
							rbyte_q <= {rbyte_q[6:0], sda_s_q[1]}; // R16
							bit_q <= bit_q + 4'h1;
						end
						else
						begin
							bit_q <= 4'h0;
							byte_q <= byte_q + 2'h1;
							if (byte_q != 2'h3 && sda_s_q[1])
							begin
								nack_q <= 1'b1; // R18
								st_q <= M_STOP;
							end
							else if (byte_q == 2'h0)
								sh_q <= idx_q; // R24
							else if (byte_q == 2'h1 && !rd_op_q)
								sh_q <= wbyte_q;
							else if (byte_q == 2'h1)
								st_q <= M_RSTART; // R24
							else if (byte_q == 2'h2 && rd_op_q)
								sh_q <= 8'hff; // R16
							else
								st_q <= M_STOP;
						end
					end
				M_RSTART:
					if (tick)
					begin
						if (bit_q == 4'h0)
						begin
							// SCL low first so the slave lets SDA go before SCL rises.
							bus.scl_oe <= 1'b1;
							bus.scl_o <= 1'b0;
							bus.msda_oe <= 1'b0;
							bit_q <= 4'h1;
						end
						else
						begin
							bus.scl_oe <= 1'b0; // R15
							byte_q <= 2'h2;
							ph_q <= 1'b0;
							st_q <= M_START;
						end
					end
				M_STOP:
					if (tick)
					begin
						// SCL low, SDA low, SCL up, then SDA up: a clean STOP.
						if (bit_q == 4'h0)
						begin
							bus.scl_oe <= 1'b1;
							bus.scl_o <= 1'b0;
							bit_q <= 4'h1;
						end
						else if (bit_q == 4'h1)
						begin
							bus.msda_oe <= 1'b1;
							bus.msda_o <= 1'b0;
							bit_q <= 4'h2;
						end
						else if (bit_q == 4'h2)
						begin
							bus.scl_oe <= 1'b0;
							bit_q <= 4'h3;
						end
						else
						begin
							bus.msda_oe <= 1'b0; // R19
							busy_q <= 1'b0;
							st_q <= M_IDLE;
						end
					end
				default: st_q <= M_IDLE;
			endcase
		end
	end
endmodule

// *** test/gar_asserts.sv ***
// Concurrent checks on the two-wire link between host master and gauge slave.
`timescale 1ns/1ps
module gar_asserts
	import gar_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic scl_oe,
	input wire logic msda_oe,
	input wire logic ssda_o,
	input wire logic ssda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ************************************************************
	// Link framing tracker.
	// ************************************************************
	logic scl_q; // SCL one cycle ago.
	logic sda_q; // SDA one cycle ago.
	logic busy_q; // Bus taken between START and STOP.
	logic first_q; // Current byte is the address byte.
	logic match_q; // Address byte named this slave.
	logic read_q; // Transfer direction is read.
	logic [3:0] cnt_q; // SCL rises seen within the current byte.
	logic [7:0] shift_q; // Bits of the current byte, first one at the top.
	logic start_w;
	logic stop_w;
	logic rise_w;
	logic ack_w;
	assign start_w = scl && scl_q && sda_q && !sda;
	assign stop_w = scl && scl_q && !sda_q && sda;
	assign rise_w = scl && !scl_q;
	assign ack_w = rise_w && (cnt_q == 4'h8);

	// Samples the wires and tracks whether the bus is taken.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy_q <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			busy_q <= start_w ? 1'b1 : (stop_w ? 1'b0 : busy_q);
		end
	end

	// Counts bits of each byte and keeps the address decision.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q <= 4'h0;
			first_q <= 1'b0;
			match_q <= 1'b0;
			read_q <= 1'b0;
			shift_q <= 8'h00;
		end
		else if (start_w)
		begin
			cnt_q <= 4'h0;
			first_q <= 1'b1;
		end
		else if (ack_w)
		begin
			cnt_q <= 4'h0;
			first_q <= 1'b0;
			match_q <= first_q ? (shift_q[7:1] == DEV_ADDR) : match_q;
			read_q <= first_q ? shift_q[0] : read_q;
		end
		else if (rise_w)
		begin
			cnt_q <= cnt_q + 4'h1;
			shift_q <= {shift_q[6:0], sda};
		end
	end

	// ************************************************************
	// Properties.
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	slave_oe_edge_a: assert property ($changed(ssda_oe) |-> !scl)
		else $error("Slave SDA enable moved while SCL high.");
	slave_data_hold_a: assert property (scl && $past(scl) && ssda_oe |-> $stable(ssda_o))
		else $error("Slave SDA value moved while SCL high.");
	addr_ack_a: assert property (ack_w && first_q && shift_q[7:1] == DEV_ADDR |-> !sda)
		else $error("Own address not acknowledged.");
	data_ack_a: assert property (ack_w && !first_q && match_q && !read_q |-> !sda)
		else $error("Written byte not acknowledged.");
	read_release_a: assert property (ack_w && !first_q && match_q && read_q |-> !ssda_oe)
		else $error("Slave held SDA in the master acknowledge slot.");
	idle_scl_a: assert property (!busy_q |-> scl)
		else $error("SCL low while the bus is free.");
	idle_sda_a: assert property (!busy_q && !start_w |-> sda)
		else $error("SDA low while the bus is free.");
	idle_release_a: assert property (!busy_q |-> !ssda_oe)
		else $error("Slave drove SDA outside a transfer.");
	reset_quiet_a: assert property (disable iff (1'b0) !i_rst_b |-> !ssda_oe && !scl_oe && !msda_oe)
		else $error("Link driven during reset.");

	cover property (start_w);
	cover property (ack_w && first_q && match_q);
	cover property (ack_w && !first_q && match_q && read_q);
endmodule

// *** test/gauge_alert_regs_i2c_slave_tb_top.sv ***
// Testbench that reaches the gauge registers through the host master command port.
`timescale 1ns/1ps
module gauge_alert_regs_i2c_slave_tb_top
	import gar_pkg::*;
();
	// ************************************************************
	// Stimulus and instances.
	// ************************************************************
	localparam longint STALE_SIM = 5000; // Short freshness window for simulation.
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_charge_pct = 8'h15; // Just above the default level.
	logic [7:0] i_temp = 8'h80; // Between both default limits.
	logic [13:0] i_id_volt = 14'h2a5c;
	logic i_host_temp_mode = 1'b0;
	logic [7:0] o_rdata;
	logic o_alert_b;
	logic [15:0] o_host_temp;
	int failures = 0;
	int cmp_count = 0;

	// Free-running system clock.
	always #2.5 i_clk = ~i_clk;

	gar_if u_gar_if();
	gar_slave #(.STALE_CYCLES(STALE_SIM)) u_gar_slave (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.bus(u_gar_if), .i_charge_pct(i_charge_pct), .i_temp(i_temp), .i_id_volt(i_id_volt),
		.i_host_temp_mode(i_host_temp_mode), .o_alert_b(o_alert_b), .o_host_temp(o_host_temp));
	gar_master #(.HALF_CYC(16)) u_gar_master (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(u_gar_if),
		.i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
	gar_asserts u_gar_asserts (.i_clk(i_clk), .i_rst_b(i_rst_b), .scl_oe(u_gar_if.scl_oe),
		.msda_oe(u_gar_if.msda_oe), .ssda_o(u_gar_if.ssda_o), .ssda_oe(u_gar_if.ssda_oe),
		.scl(u_gar_if.scl), .sda(u_gar_if.sda));

	// ************************************************************
	// Tasks.
	// ************************************************************
	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask

	// One-cycle strobe on the command port; read data is settled on return.
	task automatic cmd(input logic wr, input logic [7:0] addr, input logic [15:0] wdata);
		@(posedge i_clk);
		i_wr <= wr;
		i_rd <= !wr;
		i_addr <= addr;
		i_wdata <= wdata;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
	endtask

	// Polls the busy bit under a bound, then expects no refusal by the slave.
	task automatic wait_idle();
		int n = 0;
		repeat (4) @(posedge i_clk);
		cmd(1'b0, CMD_STATUS, 16'h0000);
		while (o_rdata[0] !== 1'b0 && n < 30000)
		begin
			cmd(1'b0, CMD_STATUS, 16'h0000);
			n++;
		end
		check({14'h0000, o_rdata[1:0]}, 16'h0000);
	endtask

	// Writes one register byte through a full link transfer.
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
		cmd(1'b1, CMD_START, {idx, data});
		wait_idle();
	endtask

	// Reads one register byte and compares it.
	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
		cmd(1'b1, CMD_START, {idx, 8'hff});
		wait_idle();
		cmd(1'b0, CMD_RDATA, 16'h0000);
		check({8'h00, o_rdata}, {8'h00, exp});
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog against a hung transfer.
	initial
	begin
		#250000;
		failures++;
		$display("ERROR at %0t: watchdog got 0x%h expected 0x%h", $time, 1'b1, 1'b0);
		finish_test();
	end

	// Main sequence.
	initial
	begin
		i_rst_b <= 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		#1;
		check({15'h0000, o_alert_b}, 16'h0001);
		check(o_host_temp, 16'h0000);
		reg_rd(REG_ALERT_CONFIG, RST_ALERT_CONFIG);
		reg_rd(REG_CHARGE_ALERT_LEVEL, 8'h14);
		reg_rd(REG_ID_VOLT_L, 8'h5c);
		reg_rd(REG_ID_VOLT_H, 8'hea);
		reg_wr(REG_ALERT_CONFIG, 8'h70);
		// Temperature reaches the upper limit: flag and a low pulse.
		@(posedge i_clk);
		i_temp <= RST_TEMP_UPPER_LIMIT;
		repeat (20) @(posedge i_clk);
		#1;
		check({15'h0000, o_alert_b}, 16'h0000);
		// Charge comes down onto the alert level.
		@(posedge i_clk);
		i_charge_pct <= 8'h14;
		reg_rd(REG_ALERT_CONFIG, 8'h73);
		@(posedge i_clk);
		i_temp <= 8'h80;
		reg_wr(REG_ALERT_CONFIG, 8'h71);
		reg_rd(REG_ALERT_CONFIG, 8'h71);
		// Host temperature in use but the low byte never refreshed.
		@(posedge i_clk);
		i_host_temp_mode <= 1'b1;
		reg_wr(REG_HOST_TEMP_H, 8'h55);
		check(o_host_temp, 16'h5500);
		reg_rd(REG_ALERT_CONFIG, 8'h73);
		reg_wr(REG_ALERT_CONFIG, 8'h50);
		// The stale alarm may set the flag in the very cycle of that write; clear it again.
		reg_wr(REG_ALERT_CONFIG, 8'h50);
		repeat (6000) @(posedge i_clk);
		reg_rd(REG_ALERT_CONFIG, 8'h50);
		finish_test();
	end
endmodule
